// File: dcc_pkg.sv
// Constants for the dual comparator control block.
// Assumes a plain register port with 3-bit address and 8-bit data.
package dcc_pkg;

  // Register port widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [2:0] CMP_CTRL_OFS = 3'h0;
  localparam logic [2:0] REF_CTRL_OFS = 3'h1;
  localparam logic [2:0] FLAGS_OFS    = 3'h2;
  localparam logic [2:0] ENABLES_OFS  = 3'h3;
  localparam logic [2:0] DIR_OFS      = 3'h4;
  localparam logic [2:0] PORT_OFS     = 3'h5;
  localparam logic [2:0] IRQ_CTRL_OFS = 3'h6;

  // Comparator control fields
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int CIS_BIT  = 3;
  localparam int INV1_BIT = 4;
  localparam int INV2_BIT = 5;
  localparam int RES1_BIT = 6;
  localparam int RES2_BIT = 7;

  // Reference control fields
  localparam int REF_EN_BIT    = 7;
  localparam int REF_RANGE_BIT = 5;
  localparam int REF_SRC_BIT   = 4;
  localparam int REF_VAL_MSB   = 3;

  // Flag, enable and interrupt control bits
  localparam int FLAG_BIT      = 6;
  localparam int ROUTE_EN_BIT  = 0;
  localparam int PERIPH_EN_BIT = 1;
  localparam int GLOBAL_EN_BIT = 2;

  // Mode codes
  localparam logic [2:0] MODE_RESET  = 3'h0;
  localparam logic [2:0] MODE_INTREF = 3'h6;
  localparam logic [2:0] MODE_OFF    = 3'h7;

  // Reset values
  localparam logic [7:0] CMP_CTRL_RST = 8'h00;
  localparam logic [7:0] REF_CTRL_RST = 8'h00;
  localparam logic [7:0] DIR_RST      = 8'hFF;

  // Routed pins and pins owned by the comparators
  localparam int         PIN_A_IDX   = 1;
  localparam int         PIN_B_IDX   = 2;
  localparam logic [7:0] ANALOG_MASK = 8'h7E;

  // Reference ladder divisors
  localparam int LOW_RANGE_DIV  = 24;
  localparam int HIGH_RANGE_DIV = 32;
  localparam int QUARTER_SHIFT  = 2;

endpackage

// File: dcc_top.sv
// Dual comparator control: mode, inversion, result routing,
// change flag and internal reference selection.
// Assumes analog levels arrive as unsigned codes, synchronous inputs.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

// Operation
// R1: Result high when positive input exceeds negative, low otherwise.
// R2: Mode 110 puts internal reference on positive input of both.
// R3: Result bits 7:6 of control register are read only.
// R4: Routing switches two pins to the unsynchronized results.
// R5: Direction bits still gate the routed pin drivers.
// R6: Bits 4 and 5 invert each result for software and pins.
// R7: Port data reads zero on analog input pins.
// R8: Flag sets whenever either comparator output changes.
// R9: Software clears flag by writing zero, sets it by writing one.
// R10: Request needs all three enables; flag sets regardless.
// R11: Any control register access ends the mismatch.
// R12: A lasting mismatch keeps setting the flag.
// R13: Comparators run during sleep; enabled flag wakes device.
// R14: Mode 111 switches both comparators off.
// R15: Wake from sleep leaves control register untouched.
// R16: Reset sets mode 000, all analog, comparators powered down.
// R17: Reference offers 16 levels per range, powers down when unused.
// R18: Low range value times span over 24; else quarter plus value/32.
// R19: Source bit picks supply rails or external reference pins.
// R20: Three-bit mode field selects one of eight modes.
// R21: Software disables the interrupt while changing mode.
// R22: Results latched on each control access, compared every clock.
module dcc_top
  import dcc_pkg::*;
#(
  parameter int VW = 10
) (
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RESET_N,
  // Register port
  input  wire logic [dcc_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [dcc_pkg::DATA_W-1:0] WDATA,
  input  wire logic                      WR,
  input  wire logic                      RD,
  output logic      [dcc_pkg::DATA_W-1:0] RDATA,
  // Analog levels as codes
  input  wire logic [VW-1:0]             C1_POS,
  input  wire logic [VW-1:0]             C1_NEG_A,
  input  wire logic [VW-1:0]             C1_NEG_B,
  input  wire logic [VW-1:0]             C2_POS,
  input  wire logic [VW-1:0]             C2_NEG_A,
  input  wire logic [VW-1:0]             C2_NEG_B,
  input  wire logic [VW-1:0]             SUPPLY_SPAN,
  input  wire logic [VW-1:0]             EXT_SPAN,
  // Port pins
  input  wire logic [7:0]                PORT_IN,
  output logic                           PIN_A_OUT,
  output logic                           PIN_A_OE,
  output logic                           PIN_B_OUT,
  output logic                           PIN_B_OE,
  // Power and reference
  output logic                           COMP_POWER_ON,
  output logic                           REF_POWER_ON,
  output logic      [VW-1:0]             REF_LEVEL,
  // Interrupt and wake
  output logic                           IRQ,
  output logic                           WAKE
);

  import dcc_pkg::*;

  // Complete block state
  typedef struct packed {
    logic [2:0]    mode;
    logic          input_switch_bit;
    logic [1:0]    inv;
    logic [7:0]    refc;
    logic          flag;
    logic          comparator_irq_enable;
    logic [7:0]    dir;
    logic          route;
    logic          peripheral_irq_enable;
    logic          global_irq_enable;
    logic [1:0]    sync1;
    logic [1:0]    sync2;
    logic [1:0]    latch;
    logic [7:0]    rdata;
    logic [VW-1:0] reflvl;
  } dcc_state_s;

  dcc_state_s q;
  dcc_state_s d;

  // Combinational helpers
  logic          active;
  logic          analog;
  logic          ctrl_acc;
  logic          mismatch;
  logic [VW-1:0] span;
  logic [VW-1:0] ref_now;
  logic [VW-1:0] pos1;
  logic [VW-1:0] pos2;
  logic [VW-1:0] neg1;
  logic [VW-1:0] neg2;
  logic [1:0]    raw;
  logic [1:0]    res;

  // Comparator decision, used for both channels
  function automatic logic cmp_out(input logic [VW-1:0] p,
                                   input logic [VW-1:0] n);
    cmp_out = (p > n);
  endfunction

  // Reference ladder tap
  function automatic logic [VW-1:0] ref_calc(input logic          rng,
                                             input logic [3:0]    v,
                                             input logic [VW-1:0] s);
    logic [VW+3:0] prod;
    prod = {{VW{1'b0}}, v} * {4'h0, s};
    if (rng) begin
      ref_calc = VW'(prod / LOW_RANGE_DIV);
    end else begin
      ref_calc = VW'((s >> QUARTER_SHIFT) + VW'(prod / HIGH_RANGE_DIV));
    end
  endfunction

  // Mode decode and source selection
  assign active   = (q.mode != MODE_RESET) && (q.mode != MODE_OFF); // [R14] [R16] [R20]
  assign analog   = (q.mode != MODE_OFF);
  assign span     = q.refc[REF_SRC_BIT] ? EXT_SPAN : SUPPLY_SPAN; // [R19]
  assign ref_now  = q.refc[REF_EN_BIT] ?
                    ref_calc(q.refc[REF_RANGE_BIT], q.refc[REF_VAL_MSB:0], span) :
                    '0; // [R17] [R18]
  assign ctrl_acc = (WR || RD) && (ADDR == CMP_CTRL_OFS);
  assign mismatch = (q.sync2 != q.latch); // [R22]

  // Input steering per mode
  always_comb begin
    pos1 = C1_POS;
    pos2 = C2_POS;
    neg1 = C1_NEG_A;
    neg2 = C2_NEG_A;
    if (q.mode == MODE_INTREF) begin
      pos1 = ref_now; // [R2]
      pos2 = ref_now; // [R2]
      neg1 = q.input_switch_bit ? C1_NEG_A : C1_NEG_B;
      neg2 = q.input_switch_bit ? C2_NEG_A : C2_NEG_B;
    end
  end

  // Raw results, zero when powered down, and polarity adjusted results
  assign raw[0] = active && cmp_out(pos1, neg1); // [R1] [R13]
  assign raw[1] = active && cmp_out(pos2, neg2); // [R1]
  assign res    = raw ^ q.inv; // [R6]

  // Next state
  always_comb begin
    d = q;

    // Two flop synchronizer of the live results
    d.sync1 = res;
    d.sync2 = q.sync1;

    // Latch results on any control register access
    if (ctrl_acc) begin
      d.latch = q.sync2; // [R11] [R22]
    end

    // Register writes
    if (WR) begin
      case (ADDR)
        CMP_CTRL_OFS: begin
          d.mode = WDATA[MODE_MSB:MODE_LSB]; // [R20]
          d.input_switch_bit  = WDATA[CIS_BIT];
          d.inv  = {WDATA[INV2_BIT], WDATA[INV1_BIT]}; // [R6]
        end
        REF_CTRL_OFS: begin
          d.refc = WDATA;
        end
        FLAGS_OFS: begin
          d.flag = WDATA[FLAG_BIT]; // [R9]
        end
        ENABLES_OFS: begin
          d.comparator_irq_enable = WDATA[FLAG_BIT];
        end
        DIR_OFS: begin
          d.dir = WDATA;
        end
        IRQ_CTRL_OFS: begin
          d.route = WDATA[ROUTE_EN_BIT];
          d.peripheral_irq_enable  = WDATA[PERIPH_EN_BIT];
          d.global_irq_enable   = WDATA[GLOBAL_EN_BIT];
        end
        default: begin
          d.route = q.route;
        end
      endcase
    end

    // Hardware set wins over a software clear
    if (mismatch) begin
      d.flag = 1'b1; // [R8] [R12]
    end

    // Read data, valid the cycle after the strobe
    d.rdata = '0;
    if (RD) begin
      case (ADDR)
        CMP_CTRL_OFS: begin
          d.rdata = {q.sync2[1], q.sync2[0], q.inv[1], q.inv[0],
                     q.input_switch_bit, q.mode}; // [R3]
        end
        REF_CTRL_OFS: begin
          d.rdata = q.refc;
        end
        FLAGS_OFS: begin
          d.rdata[FLAG_BIT] = q.flag;
        end
        ENABLES_OFS: begin
          d.rdata[FLAG_BIT] = q.comparator_irq_enable;
        end
        DIR_OFS: begin
          d.rdata = q.dir;
        end
        PORT_OFS: begin
          d.rdata = analog ? (PORT_IN & ~ANALOG_MASK) : PORT_IN; // [R7]
        end
        IRQ_CTRL_OFS: begin
          d.rdata[ROUTE_EN_BIT]  = q.route;
          d.rdata[PERIPH_EN_BIT] = q.peripheral_irq_enable;
          d.rdata[GLOBAL_EN_BIT] = q.global_irq_enable;
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end

    // Registered reference level
    d.reflvl = ref_now;
  end

  // State register; no sleep input touches it
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q.mode   <= CMP_CTRL_RST[MODE_MSB:MODE_LSB]; // [R16]
      q.input_switch_bit    <= CMP_CTRL_RST[CIS_BIT];
      q.inv    <= {CMP_CTRL_RST[INV2_BIT], CMP_CTRL_RST[INV1_BIT]};
      q.refc   <= REF_CTRL_RST;
      q.flag   <= 1'b0;
      q.comparator_irq_enable   <= 1'b0;
      q.dir    <= DIR_RST;
      q.route  <= 1'b0;
      q.peripheral_irq_enable   <= 1'b0;
      q.global_irq_enable    <= 1'b0;
      q.sync1  <= 2'h0;
      q.sync2  <= 2'h0;
      q.latch  <= 2'h0;
      q.rdata  <= 8'h00;
      q.reflvl <= '0;
    end else begin
      q <= d; // [R15]
    end
  end

  // Routed pins carry the live result, drivers gated by direction
  assign PIN_A_OUT = q.route && res[0]; // [R4]
  assign PIN_B_OUT = q.route && res[1]; // [R4]
  assign PIN_A_OE  = q.route && !q.dir[PIN_A_IDX]; // [R5]
  assign PIN_B_OE  = q.route && !q.dir[PIN_B_IDX]; // [R5]

  // Power, reference and read data outputs
  assign COMP_POWER_ON = RESET_N && active; // [R16]
  assign REF_POWER_ON  = q.refc[REF_EN_BIT]; // [R17]
  assign REF_LEVEL     = q.reflvl;
  assign RDATA         = q.rdata;

  // Request and wake
  assign IRQ  = q.flag && q.comparator_irq_enable && q.peripheral_irq_enable && q.global_irq_enable; // [R10]
  assign WAKE = q.flag && q.comparator_irq_enable; // [R13]

  // Checks

  AST_INTREF: assert property (@(posedge CLK) disable iff (!RESET_N) // [R2]
    (q.mode == MODE_INTREF) |->
      raw[0] == (ref_now > (q.input_switch_bit ? C1_NEG_A : C1_NEG_B)))
    else $error("Internal reference not on positive input");

  AST_RESULT_READ: assert property (@(posedge CLK) disable iff (!RESET_N) // [R3]
    (RD && ADDR == CMP_CTRL_OFS) |=>
      RDATA[RES2_BIT:RES1_BIT] == $past(q.sync2))
    else $error("Result bits read wrong");

  AST_ROUTE: assert property (@(posedge CLK) disable iff (!RESET_N) // [R4]
    q.route |-> (PIN_A_OUT == (raw[0] ^ q.inv[0])))
    else $error("Routed pin A wrong");

  AST_OE: assert property (@(posedge CLK) disable iff (!RESET_N) // [R5]
    (q.route && q.dir[PIN_B_IDX]) |-> !PIN_B_OE)
    else $error("Pin B driven while input");

  AST_INV: assert property (@(posedge CLK) disable iff (!RESET_N) // [R6]
    (q.route && q.inv[1]) |-> (PIN_B_OUT != raw[1]))
    else $error("Inversion not applied");

  AST_PORT_ZERO: assert property (@(posedge CLK) disable iff (!RESET_N) // [R7]
    (RD && ADDR == PORT_OFS && analog) |=> ((RDATA & ANALOG_MASK) == 8'h00))
    else $error("Analog pin read nonzero");

  AST_FLAG_SET: assert property (@(posedge CLK) disable iff (!RESET_N) // [R8]
    mismatch |=> q.flag)
    else $error("Flag not set on change");

  AST_SW_SET: assert property (@(posedge CLK) disable iff (!RESET_N) // [R9]
    (WR && ADDR == FLAGS_OFS && WDATA[FLAG_BIT]) |=> q.flag)
    else $error("Software set lost");

  AST_IRQ_GATE: assert property (@(posedge CLK) disable iff (!RESET_N) // [R10]
    (!q.global_irq_enable || !q.peripheral_irq_enable) |-> !IRQ)
    else $error("Request without enables");

  AST_LATCH: assert property (@(posedge CLK) disable iff (!RESET_N) // [R11]
    ctrl_acc |=> (q.latch == $past(q.sync2)))
    else $error("Access did not latch results");

  AST_OFF: assert property (@(posedge CLK) disable iff (!RESET_N) // [R14]
    (q.mode == MODE_OFF) |-> (raw == 2'h0) && !COMP_POWER_ON)
    else $error("Comparators not off");

  AST_REF: assert property (@(posedge CLK) disable iff (!RESET_N) // [R18]
    q.refc[REF_EN_BIT] && $stable(q.refc) && $stable(span) |->
      REF_LEVEL == ref_calc(q.refc[REF_RANGE_BIT], q.refc[REF_VAL_MSB:0], span))
    else $error("Reference level wrong");

  AST_WAKE: assert property (@(posedge CLK) disable iff (!RESET_N) // [R13]
    (q.flag && q.comparator_irq_enable) |-> WAKE)
    else $error("Wake missing");

  // Flag clear, hold and enable independence
  AST_SW_CLEAR: assert property (@(posedge CLK) disable iff (!RESET_N) // [R9]
    (WR && ADDR == FLAGS_OFS && !WDATA[FLAG_BIT] && !mismatch) |=> !q.flag)
    else $error("Software clear lost");

  AST_KEEP_SET: assert property (@(posedge CLK) disable iff (!RESET_N) // [R12]
    (mismatch && WR && ADDR == FLAGS_OFS) |=> q.flag)
    else $error("Clear beat a lasting mismatch");

  AST_FLAG_UNGATED: assert property (@(posedge CLK) disable iff (!RESET_N) // [R10]
    (mismatch && !IRQ) |=> q.flag)
    else $error("Flag not set while request gated");

  // Reset mode, mode writes and register hold
  AST_RESET_MODE: assert property (@(posedge CLK) disable iff (!RESET_N) // [R16]
    (q.mode == MODE_RESET) |-> (raw == 2'h0) && !COMP_POWER_ON)
    else $error("Comparators alive in reset mode");

  AST_MODE_WRITE: assert property (@(posedge CLK) disable iff (!RESET_N) // [R20]
    (WR && ADDR == CMP_CTRL_OFS) |=> (q.mode == $past(WDATA[MODE_MSB:MODE_LSB])))
    else $error("Mode field not written");

  AST_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N) // [R15]
    !(WR && ADDR == CMP_CTRL_OFS) |=> $stable({q.mode, q.input_switch_bit, q.inv}))
    else $error("Control register changed without a write");

  // Reference power down and source
  AST_REF_OFF: assert property (@(posedge CLK) disable iff (!RESET_N) // [R17]
    !REF_POWER_ON |=> (REF_LEVEL == {VW{1'b0}}))
    else $error("Reference level while powered down");

  AST_SRC: assert property (@(posedge CLK) disable iff (!RESET_N) // [R19]
    q.refc[REF_SRC_BIT] |-> (span == EXT_SPAN))
    else $error("Reference source not external");

  // Change detect path and digital port reads
  AST_SYNC: assert property (@(posedge CLK) disable iff (!RESET_N) // [R22]
    q.sync2 == $past(res, 2))
    else $error("Synchronised result out of step");

  AST_PORT_DIGITAL: assert property (@(posedge CLK) disable iff (!RESET_N) // [R7]
    (RD && ADDR == PORT_OFS && !analog) |=> (RDATA == $past(PORT_IN)))
    else $error("Digital port read wrong");

endmodule

// File: testbench.sv
// Self-checking bench for the dual comparator control block.
// Assumes dcc_pkg and dcc_top are compiled first; register port as per hand-over.
`timescale 1ns/1ps

`define CHK(A, E) begin checked++; if ((A) !== (E)) begin miscompares++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, A, E); end end

module testbench;
  import dcc_pkg::*;

  logic       clk, reset_n, wr_s, rd_s;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, port_in, d;
  logic [9:0] c1p, c1a, c1b, c2p, c2a, c2b, sspan, espan, ref_level;
  logic       pa, pa_oe, pb, pb_oe, comp_on, ref_on, irq, wake;
  int         miscompares = 0;
  int         checked = 0;
  int         cycles = 0;
  logic [7:0] rv [6] = '{8'hAC, 8'h8C, 8'h9C, 8'h0C, 8'hAF, 8'h80};
  logic [9:0] rl [6] = '{10'h1E0, 10'h258, 10'h12C, 10'h000, 10'h258, 10'h0F0};
  logic [2:0] ra [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  logic [7:0] re [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};

  dcc_top #(.VW(10)) u_dcc_top (
    .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .C1_POS(c1p), .C1_NEG_A(c1a), .C1_NEG_B(c1b), .C2_POS(c2p),
    .C2_NEG_A(c2a), .C2_NEG_B(c2b), .SUPPLY_SPAN(sspan), .EXT_SPAN(espan),
    .PORT_IN(port_in), .PIN_A_OUT(pa), .PIN_A_OE(pa_oe), .PIN_B_OUT(pb), .PIN_B_OE(pb_oe),
    .COMP_POWER_ON(comp_on), .REF_POWER_ON(ref_on), .REF_LEVEL(ref_level),
    .IRQ(irq), .WAKE(wake));

  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      results();
    end
  end

  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe; data sampled in the following cycle only
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask

  // Results pass two synchroniser flops before software sees them
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic results();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 0; reset_n = 0; wr_s = 0; rd_s = 0; addr = 3'h0; wdata = 8'h00;
    c1p = 10'h0C8; c1a = 10'h064; c1b = 10'h1F4; c2p = 10'h032; c2a = 10'h064;
    c2b = 10'h190; sspan = 10'h3C0; espan = 10'h1E0; port_in = 8'hFF;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values and the unmapped address
    for (int i = 0; i < 6; i++) rdc(ra[i], re[i]);
    `CHK(comp_on, 1'b0)
    // Mode 001: first result high, second low; change raises the flag
    wr(3'h0, 8'h01);
    `CHK(comp_on, 1'b1)
    settle();
    rdc(3'h2, 8'h40);
    rdc(3'h0, 8'h41);
    wr(3'h2, 8'h00);
    rdc(3'h2, 8'h00);
    // Lasting mismatch keeps re-setting the flag until a control access
    @(posedge clk) c2p <= 10'h12C;
    settle();
    wr(3'h2, 8'h00);
    rdc(3'h2, 8'h40);
    rdc(3'h0, 8'hC1);
    wr(3'h2, 8'h00);
    rdc(3'h2, 8'h00);
    // Software-set flag and the three enables
    wr(3'h2, 8'h40);
    rdc(3'h2, 8'h40);
    `CHK(({irq, wake}), 2'b00)
    wr(3'h3, 8'h40);
    `CHK(({irq, wake}), 2'b01)
    wr(3'h6, 8'h02);
    `CHK(irq, 1'b0)
    wr(3'h6, 8'h06);
    `CHK(irq, 1'b1)
    wr(3'h3, 8'h00); // Interrupt stays off for the mode changes below
    `CHK(({irq, wake}), 2'b00)
    wr(3'h6, 8'h00);
    // Inversion, read-only result bits and routing to the pins
    wr(3'h0, 8'hF1);
    settle();
    rdc(3'h0, 8'h31);
    wr(3'h6, 8'h01);
    wr(3'h4, 8'hF9);
    `CHK(({pa_oe, pb_oe, pa, pb}), 4'b1100)
    wr(3'h0, 8'h01);
    `CHK(({pa, pb}), 2'b11)
    wr(3'h4, 8'hFB);
    `CHK(({pa_oe, pb_oe}), 2'b01)
    wr(3'h4, 8'hFF);
    `CHK(({pa_oe, pb_oe}), 2'b00)
    wr(3'h6, 8'h00);
    // Analog pins read zero; mode 111 turns comparators off
    rdc(3'h5, 8'h81);
    wr(3'h0, 8'h07);
    `CHK(comp_on, 1'b0)
    rdc(3'h5, 8'hFF);
    settle();
    rdc(3'h0, 8'h07);
    // Reference ladder settings
    for (int i = 0; i < 6; i++) begin
      wr(3'h1, rv[i]);
      @(posedge clk);
      #1;
      `CHK(ref_level, rl[i])
      `CHK(ref_on, rv[i][7])
    end
    // Mode 110: internal reference on both positive inputs
    wr(3'h1, 8'hAC);
    wr(3'h0, 8'h06);
    settle();
    rdc(3'h0, 8'h86);
    wr(3'h0, 8'h0E);
    settle();
    rdc(3'h0, 8'hCE);
    // Every mode code
    for (int i = 0; i < 8; i++) begin
      wr(3'h0, {5'h00, i[2:0]});
      `CHK(comp_on, (i != 0 && i != 7))
      rd(3'h0, d);
      `CHK(d[2:0], i[2:0])
    end
    // Reset in mid-run
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(({comp_on, irq, pa_oe}), 3'b000)
    @(posedge clk) reset_n <= 1'b1;
    rdc(3'h0, 8'h00);
    rdc(3'h4, 8'hFF);
    results();
  end
endmodule
